// [include/slpcs_pkg.sv]
// constants, register map and state type for the sleep and module clock stop block
`default_nettype none

package slpcs_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFF_STBC2  = 8'h00;
  localparam logic [7:0] OFF_PSTOP  = 8'h04;
  localparam logic [7:0] OFF_PCLR   = 8'h08;
  localparam logic [7:0] OFF_STBC1  = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  //////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int STBC2_DEEP   = 7;
  localparam int STBC2_PINDRV = 6;
  localparam int STBC2_QSTOP  = 1;
  localparam int STBC2_BRK    = 0;
  localparam int STBC1_SBSEL  = 7;
  localparam int PSTOP_PCI    = 2;
  localparam int PSTOP_TMR    = 1;
  localparam int PSTOP_IRQC   = 0;
  localparam int STAT_SLEEP   = 0;
  localparam int STAT_DEEP    = 1;
  localparam int STAT_STANDBY = 2;
  localparam int STAT_HWSB  = 3;
  localparam int STAT_PINS  = 4;

  //////////////////////////////////////////////////////////////////////////////
  // reset values and writable masks
  localparam logic [7:0]  STBC2_RST   = 8'h00;
  localparam logic [7:0]  STBC2_WMASK = 8'hC3;
  localparam logic [7:0]  STBC1_RST   = 8'h00;
  localparam logic [7:0]  STBC1_WMASK = 8'h80;
  localparam logic [31:0] PSTOP_RST   = 32'h00000000;
  localparam logic [31:0] PSTOP_WMASK = 32'h00000007;

  //////////////////////////////////////////////////////////////////////////////
  // state pin codes, high pin first
  localparam logic [1:0] PINS_RESET   = 2'h3;
  localparam logic [1:0] PINS_SLEEP   = 2'h2;
  localparam logic [1:0] PINS_STANDBY = 2'h1;
  localparam logic [1:0] PINS_RUN     = 2'h0;

  // number of gated module clocks
  localparam int NGATE = 5;

  typedef enum logic [2:0] {
    SLPCS_RST,
    SLPCS_RUN,
    SLPCS_SLEEP,
    SLPCS_DEEP,
    SLPCS_STANDBY
  } slpcs_state_t;

endpackage : slpcs_pkg

`default_nettype wire

// [hdl/slpcs_clk_gate.sv]
// glitch-free clock gate for one on-chip module
`default_nettype none

module slpcs_clk_gate (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic stop,
  output logic      gclk
);

  logic run_r;

  ////////////////////////////////////////////////////////////////////////////
  // enable moves only while clk is low, so the and gate never slices a pulse
  always_ff @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_r <= 1'b1;
    end else begin
      run_r <= ~stop;
    end
  end

  assign gclk = clk & run_r;

  ////////////////////////////////////////////////////////////////////////////
  // gclk is always low when sampled at a rising edge, so the enable is watched instead
  gate_quiet_a: assert property (
    @(posedge clk) disable iff (!arst_n) stop [*2] |-> !run_r
  ) else $error("gate enable still on while stopped");

endmodule : slpcs_clk_gate

`default_nettype wire

// [hdl/slpcs_top.sv]
// sleep sequencing, standby control registers and module clock stops
//
// The APB slave port and the address map were chosen for this implementation.
`default_nettype none

module slpcs_top #(
  parameter int ADDR_W = 8,
  parameter int EVT_W  = 12
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sleep_instr,
  input  wire logic              manual_reset,
  input  wire logic              hw_standby,
  input  wire logic              nmi_req,
  input  wire logic              level_irq_req,
  input  wire logic              periph_irq_req,
  input  wire logic              irq_block_bit,
  input  wire logic [EVT_W-1:0]  wake_code,
  output logic                   cpu_halt,
  output logic                   wake_exc,
  output logic      [EVT_W-1:0]  event_code,
  output logic                   irq_take,
  output logic                   clock_output_run,
  output logic                   state_out_hi,
  output logic                   state_out_lo,
  output logic                   state_pin_oe,
  output logic                   store_queue_clk,
  output logic                   break_clk,
  output logic                   pci_clk,
  output logic                   timer34_clk,
  output logic                   irqc_clk
);

  //////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie in 5..32");
  end
  if (EVT_W < 1 || EVT_W > 32) begin : g_bad_evt
    $error("EVT_W must lie in 1..32");
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]                stbc2_r;
  logic [7:0]                stbc2_nxt;
  logic [7:0]                stbc1_r;
  logic [7:0]                stbc1_nxt;
  logic [31:0]               pstop_r;
  logic [31:0]               pstop_nxt;
  slpcs_pkg::slpcs_state_t   state_r;
  slpcs_pkg::slpcs_state_t   state_nxt;
  logic [1:0]                pins_r;
  logic [1:0]                pins_nxt;
  logic                      oe_r;
  logic                      oe_nxt;
  logic                      halt_r;
  logic                      wake_r;
  logic [EVT_W-1:0]          evt_r;
  logic                      take_r;
  logic                      ckrun_r;
  logic [31:0]               prdata_r;
  logic                      pready_r;
  logic                      pslverr_r;

  //////////////////////////////////////////////////////////////////////////////
  // address decode, shared by read mux and write strobes
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  wire hit_stbc2  = hit(paddr, slpcs_pkg::OFF_STBC2);
  wire hit_pstop  = hit(paddr, slpcs_pkg::OFF_PSTOP);
  wire hit_pclr   = hit(paddr, slpcs_pkg::OFF_PCLR);
  wire hit_stbc1  = hit(paddr, slpcs_pkg::OFF_STBC1);
  wire hit_status = hit(paddr, slpcs_pkg::OFF_STATUS);
  wire hit_any    = hit_stbc2 | hit_pstop | hit_pclr | hit_stbc1 | hit_status;

  // pready is a flop, so each access phase lasts exactly two cycles
  wire acc_first = psel & penable & ~pready_r;
  wire acc_done  = psel & penable & pready_r;
  wire wr_ok     = acc_done & pwrite;
  wire wr_stbc2  = wr_ok & hit_stbc2;
  wire wr_stbc1  = wr_ok & hit_stbc1;
  wire wr_pstop  = wr_ok & hit_pstop;
  wire wr_pclr   = wr_ok & hit_pclr;

  //////////////////////////////////////////////////////////////////////////////
  // status word and read mux; clear register and holes read as zero
  wire asleep = (state_r == slpcs_pkg::SLPCS_SLEEP) | (state_r == slpcs_pkg::SLPCS_DEEP)
              | (state_r == slpcs_pkg::SLPCS_STANDBY);

  logic [31:0] status_w;
  always_comb begin
    status_w = 32'h00000000;
    status_w[slpcs_pkg::STAT_SLEEP] = (state_r == slpcs_pkg::SLPCS_SLEEP);
    status_w[slpcs_pkg::STAT_DEEP]  = (state_r == slpcs_pkg::SLPCS_DEEP);
    status_w[slpcs_pkg::STAT_STANDBY] = (state_r == slpcs_pkg::SLPCS_STANDBY);
    status_w[slpcs_pkg::STAT_HWSB]  = hw_standby;
    status_w[slpcs_pkg::STAT_PINS +: 2] = pins_r;
  end

  wire [31:0] rd_data = hit_stbc2  ? {24'h000000, stbc2_r} :
                        hit_pstop  ? pstop_r :
                        hit_stbc1  ? {24'h000000, stbc1_r} :
                        hit_status ? status_w : 32'h00000000;

  //////////////////////////////////////////////////////////////////////////////
  // apb slave answer, loaded in the first access cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= acc_first;
      prdata_r  <= (acc_first & ~pwrite) ? rd_data : 32'h00000000;
      pslverr_r <= acc_first & ~hit_any;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // standby control registers; reserved bits are masked so they never store
  assign stbc2_nxt = wr_stbc2 ? (pwdata[7:0] & slpcs_pkg::STBC2_WMASK) : stbc2_r;
  assign stbc1_nxt = wr_stbc1 ? (pwdata[7:0] & slpcs_pkg::STBC1_WMASK) : stbc1_r;

  // manual reset leaves these alone: only power-on or watchdog clears them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stbc2_r <= slpcs_pkg::STBC2_RST;
      stbc1_r <= slpcs_pkg::STBC1_RST;
    end else begin
      stbc2_r <= stbc2_nxt;
      stbc1_r <= stbc1_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // peripheral stop: write-one-to-set, separate write-one-to-clear, clear wins
  wire [31:0] set_bits = wr_pstop ? (pwdata & slpcs_pkg::PSTOP_WMASK) : 32'h00000000;
  wire [31:0] clr_bits = wr_pclr ? pwdata : 32'h00000000;
  assign pstop_nxt = manual_reset ? slpcs_pkg::PSTOP_RST
                   : ((pstop_r | set_bits) & ~clr_bits);

  // standby does not touch this register, so settings survive it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pstop_r <= slpcs_pkg::PSTOP_RST;
    end else begin
      pstop_r <= pstop_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power state sequencing
  wire any_req     = nmi_req | level_irq_req | periph_irq_req;
  wire standby_sel = stbc1_r[slpcs_pkg::STBC1_SBSEL];
  wire deep_sel    = stbc2_r[slpcs_pkg::STBC2_DEEP];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      slpcs_pkg::SLPCS_RST: begin
        state_nxt = slpcs_pkg::SLPCS_RUN;
      end
      slpcs_pkg::SLPCS_RUN: begin
        if (sleep_instr) begin
          if (standby_sel) begin
            state_nxt = slpcs_pkg::SLPCS_STANDBY;
          end else if (deep_sel) begin
            state_nxt = slpcs_pkg::SLPCS_DEEP;
          end else begin
            state_nxt = slpcs_pkg::SLPCS_SLEEP;
          end
        end
      end
      slpcs_pkg::SLPCS_SLEEP, slpcs_pkg::SLPCS_DEEP, slpcs_pkg::SLPCS_STANDBY: begin
        // the block bit is not consulted: any request wakes the core
        if (any_req) begin
          state_nxt = slpcs_pkg::SLPCS_RUN;
        end
      end
      default: begin
        state_nxt = slpcs_pkg::SLPCS_RUN;
      end
    endcase
    if (manual_reset) begin
      state_nxt = slpcs_pkg::SLPCS_RST;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state pin encoding, taken from the next state so pins line up with state_r
  always_comb begin
    oe_nxt = 1'b1;
    case (state_nxt)
      slpcs_pkg::SLPCS_RST:   pins_nxt = slpcs_pkg::PINS_RESET;
      slpcs_pkg::SLPCS_SLEEP: pins_nxt = slpcs_pkg::PINS_SLEEP;
      slpcs_pkg::SLPCS_DEEP:  pins_nxt = slpcs_pkg::PINS_SLEEP;
      slpcs_pkg::SLPCS_STANDBY: pins_nxt = slpcs_pkg::PINS_STANDBY;
      default:                pins_nxt = slpcs_pkg::PINS_RUN;
    endcase
    // hardware standby overrides everything but reset
    if (hw_standby && !manual_reset) begin
      pins_nxt = slpcs_pkg::PINS_STANDBY;
      oe_nxt   = stbc2_r[slpcs_pkg::STBC2_PINDRV];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state, pins and core-facing flags
  wire wake_now = asleep & any_req & ~manual_reset;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= slpcs_pkg::SLPCS_RST;
      pins_r  <= slpcs_pkg::PINS_RESET;
      oe_r    <= 1'b1;
      halt_r  <= 1'b0;
      ckrun_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      pins_r  <= pins_nxt;
      oe_r    <= oe_nxt;
      halt_r  <= (state_nxt != slpcs_pkg::SLPCS_RUN);
      ckrun_r <= (state_nxt != slpcs_pkg::SLPCS_STANDBY);
    end
  end

  // wake pulse carries the source code; the code holds until the next wake
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_r <= 1'b0;
      evt_r  <= '0;
      take_r <= 1'b0;
    end else begin
      wake_r <= wake_now;
      evt_r  <= wake_now ? wake_code : evt_r;
      take_r <= any_req & (asleep | ~irq_block_bit) & ~manual_reset;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // module clock gates
  wire [slpcs_pkg::NGATE-1:0] gate_stop = {
    pstop_r[slpcs_pkg::PSTOP_PCI],
    pstop_r[slpcs_pkg::PSTOP_TMR],
    pstop_r[slpcs_pkg::PSTOP_IRQC],
    stbc2_r[slpcs_pkg::STBC2_QSTOP],
    stbc2_r[slpcs_pkg::STBC2_BRK]
  };
  logic [slpcs_pkg::NGATE-1:0] gclk;

  for (genvar g = 0; g < slpcs_pkg::NGATE; g++) begin : g_gate
    slpcs_clk_gate u_gate (
      .clk    (clk),
      .arst_n (arst_n),
      .stop   (gate_stop[g]),
      .gclk   (gclk[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign cpu_halt         = halt_r;
  assign wake_exc         = wake_r;
  assign event_code       = evt_r;
  assign irq_take         = take_r;
  assign clock_output_run = ckrun_r;
  assign state_out_hi     = pins_r[1];
  assign state_out_lo     = pins_r[0];
  assign state_pin_oe     = oe_r;
  assign pci_clk          = gclk[4];
  assign timer34_clk      = gclk[3];
  assign irqc_clk         = gclk[2];
  assign store_queue_clk  = gclk[1];
  assign break_clk        = gclk[0];

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  rsv_read_a: assert property (
    acc_first && !pwrite && hit_stbc2 |=> prdata_r[5:2] == 4'h0 && pready_r
  ) else $error("reserved standby bits read nonzero");

  stop_hold_a: assert property (
    !wr_pstop && !wr_pclr && !manual_reset |=> $stable(pstop_r)
  ) else $error("stop register moved without a write");

  stop_set_a: assert property (
    wr_pstop && !wr_pclr && !manual_reset
      |=> (pstop_r & $past(pwdata) & slpcs_pkg::PSTOP_WMASK)
          == ($past(pwdata) & slpcs_pkg::PSTOP_WMASK)
  ) else $error("set write did not set stop bits");

  stop_clear_a: assert property (
    wr_pclr |=> (pstop_r & $past(pwdata)) == 32'h00000000
  ) else $error("clear write left a stop bit set");

  sleep_entry_a: assert property (
    state_r == slpcs_pkg::SLPCS_RUN && sleep_instr && !standby_sel && !deep_sel && !manual_reset
      |=> state_r == slpcs_pkg::SLPCS_SLEEP && halt_r && ckrun_r
  ) else $error("plain sleep not entered");

  sleep_pins_a: assert property (
    state_r == slpcs_pkg::SLPCS_SLEEP && !$past(hw_standby)
      |-> state_out_hi && !state_out_lo && state_pin_oe
  ) else $error("sleep pin code wrong");

  wake_code_a: assert property (
    wake_now |=> wake_r && state_r == slpcs_pkg::SLPCS_RUN && evt_r == $past(wake_code)
      ##1 !wake_r
  ) else $error("wake did not load event code");

  reset_exit_a: assert property (
    manual_reset |=> state_r == slpcs_pkg::SLPCS_RST && pins_r == slpcs_pkg::PINS_RESET
      && pstop_r == slpcs_pkg::PSTOP_RST
  ) else $error("manual reset did not force reset state");

  hw_float_a: assert property (
    hw_standby && !manual_reset |=> pins_r == slpcs_pkg::PINS_STANDBY
      && oe_r == $past(stbc2_r[slpcs_pkg::STBC2_PINDRV])
  ) else $error("hardware standby pin drive wrong");

  sleep_cov_c:  cover property (state_r == slpcs_pkg::SLPCS_SLEEP ##1 wake_r);
  deep_cov_c:   cover property (state_r == slpcs_pkg::SLPCS_DEEP);
  standby_cov_c: cover property (state_r == slpcs_pkg::SLPCS_STANDBY ##[1:20] wake_r);
  clrset_cov_c: cover property (wr_pstop ##[1:20] wr_pclr);

endmodule : slpcs_top

`default_nettype wire

// [bench/slpcs_clk_model.sv]
// behavioural model of the on-chip modules that receive the gated clocks
`default_nettype none

module slpcs_clk_model (
  input  wire logic [4:0]  gclk,
  output logic      [15:0] cnt [5],
  output logic      [7:0]  glitch [5]
);
  timeunit 1ns;
  timeprecision 1ps;

  //////////////////////////////////////////////////////////////////////////////
  // each module counts its clock edges; a high phase shorter than about half
  // a period means the gate cut a pulse, which would upset real flops
  for (genvar i = 0; i < 5; i++) begin : g_mod
    realtime rise_t = -100.0;  // the x to 0 step at time zero is not a glitch
    initial begin
      cnt[i] = '0;
      glitch[i] = '0;
    end
    always @(posedge gclk[i]) begin
      cnt[i] <= cnt[i] + 16'h0001;
      rise_t = $realtime;
    end
    always @(negedge gclk[i]) begin
      if ($realtime - rise_t < 24.0) glitch[i] <= glitch[i] + 8'h01;
    end
  end
endmodule : slpcs_clk_model

`default_nettype wire

// [bench/slpcs_top_tb.sv]
// self-checking bench for the sleep sequencer and module clock stops
`default_nettype none

module slpcs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] A_C2 = slpcs_pkg::OFF_STBC2;
  localparam logic [7:0] A_PS = slpcs_pkg::OFF_PSTOP;
  localparam logic [7:0] A_CL = slpcs_pkg::OFF_PCLR;
  localparam logic [7:0] A_C1 = slpcs_pkg::OFF_STBC1;
  localparam logic [7:0] A_ST = slpcs_pkg::OFF_STATUS;

  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] exp;
    logic        err;
  } slpcs_row_t;

  typedef struct {
    logic [7:0]  c2;
    logic [7:0]  c1;
    int          src;
    logic [1:0]  pins;
    logic        run;
    logic [31:0] stat;
  } slpcs_mode_t;

  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sleep_instr, manual_reset, hw_standby, err;
  logic        nmi_req, level_irq_req, periph_irq_req, irq_block_bit;
  logic [11:0] wake_code, event_code;
  logic        cpu_halt, wake_exc, irq_take, clock_output_run;
  logic        state_out_hi, state_out_lo, state_pin_oe;
  logic        store_queue_clk, break_clk, pci_clk, timer34_clk, irqc_clk;
  logic [15:0] cnt [5];
  logic [15:0] snap [5];
  logic [7:0]  glitch [5];
  int          error_cnt = 0;
  int          comparisons = 0;

  // register cases: a write row expects zero read data back
  slpcs_row_t rows [16] = '{
    '{1'h0, A_C2, 32'h0, 32'h0, 1'h0},
    '{1'h0, A_PS, 32'h0, 32'h0, 1'h0},
    '{1'h0, A_C1, 32'h0, 32'h0, 1'h0},
    '{1'h1, A_C2, 32'hC3, 32'h0, 1'h0},
    '{1'h0, A_C2, 32'h0, 32'hC3, 1'h0},
    '{1'h1, A_C2, 32'h0, 32'h0, 1'h0},
    '{1'h1, A_PS, 32'h5, 32'h0, 1'h0},
    '{1'h1, A_PS, 32'h0, 32'h0, 1'h0},
    '{1'h0, A_PS, 32'h0, 32'h5, 1'h0},
    '{1'h1, A_PS, 32'h2, 32'h0, 1'h0},
    '{1'h0, A_PS, 32'h0, 32'h7, 1'h0},
    '{1'h1, A_CL, 32'h3, 32'h0, 1'h0},
    '{1'h0, A_PS, 32'h0, 32'h4, 1'h0},
    '{1'h0, A_CL, 32'h0, 32'h0, 1'h0},
    '{1'h1, 8'h14, 32'h1, 32'h0, 1'h1},
    '{1'h0, 8'h14, 32'h0, 32'h0, 1'h1}
  };

  // sleep targets: plain sleep, deep sleep, standby over deep, standby
  slpcs_mode_t modes [4] = '{
    '{8'h00, 8'h00, 0, 2'h2, 1'h1, 32'h21},
    '{8'h80, 8'h00, 1, 2'h2, 1'h1, 32'h22},
    '{8'h80, 8'h80, 2, 2'h1, 1'h0, 32'h14},
    '{8'h00, 8'h80, 0, 2'h1, 1'h0, 32'h14}
  };

  slpcs_top i_slpcs_top (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_instr(sleep_instr), .manual_reset(manual_reset), .hw_standby(hw_standby),
    .nmi_req(nmi_req), .level_irq_req(level_irq_req), .periph_irq_req(periph_irq_req),
    .irq_block_bit(irq_block_bit), .wake_code(wake_code), .cpu_halt(cpu_halt),
    .wake_exc(wake_exc), .event_code(event_code), .irq_take(irq_take),
    .clock_output_run(clock_output_run), .state_out_hi(state_out_hi),
    .state_out_lo(state_out_lo), .state_pin_oe(state_pin_oe), .store_queue_clk(store_queue_clk),
    .break_clk(break_clk), .pci_clk(pci_clk), .timer34_clk(timer34_clk), .irqc_clk(irqc_clk)
  );

  slpcs_clk_model i_slpcs_clk_model (
    .gclk({store_queue_clk, break_clk, pci_clk, timer34_clk, irqc_clk}),
    .cnt(cnt), .glitch(glitch)
  );

  //////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // one apb transfer; the request stands until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    // look just after each edge, so a flop loaded at that edge is never raced
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      conclude();
    end
    // the answer stands until the next edge, which is the one completing the transfer
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // one-cycle sleep instruction, then the entered state is looked at
  task automatic enter_sleep(input logic [1:0] pins, input logic run);
    @(posedge clk);
    sleep_instr <= 1'h1;
    @(posedge clk);
    sleep_instr <= 1'h0;
    #1;
    check(cpu_halt, 1'h1);
    check({state_out_hi, state_out_lo}, pins);
    check(clock_output_run, run);
  endtask : enter_sleep

  // one-cycle request from source src (0 nmi, 1 level, 2 peripheral)
  task automatic wake(input int src, input logic [11:0] code);
    @(posedge clk);
    {nmi_req, level_irq_req, periph_irq_req} <= 3'h4 >> src;
    wake_code <= code;
    @(posedge clk);
    {nmi_req, level_irq_req, periph_irq_req} <= 3'h0;
    #1;
    check(wake_exc, 1'h1);
    check(irq_take, 1'h1);
    check(event_code, code);
    check({cpu_halt, state_out_hi, state_out_lo}, 3'h0);
    @(posedge clk);
    #1;
    check(wake_exc, 1'h0);
  endtask : wake

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {arst_n, psel, penable, pwrite, sleep_instr, manual_reset, hw_standby} = '0;
    {nmi_req, level_irq_req, periph_irq_req, irq_block_bit} = '0;
    paddr = '0;
    pwdata = '0;
    wake_code = '0;
    repeat (10) @(posedge clk);
    arst_n <= 1'h1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      check(rd, rows[i].exp);
      check(err, rows[i].err);
    end
    // every module clock held still, then released on whole periods
    apb(1'h1, A_C2, 32'h3);
    apb(1'h1, A_PS, 32'h7);
    repeat (3) @(posedge clk);
    #1 snap = cnt;
    repeat (10) @(posedge clk);
    #1;
    foreach (cnt[i]) check(cnt[i], snap[i]);
    apb(1'h1, A_C2, 32'h0);
    apb(1'h1, A_CL, 32'h7);
    repeat (3) @(posedge clk);
    #1 snap = cnt;
    repeat (10) @(posedge clk);
    #1;
    foreach (cnt[i]) check(cnt[i], snap[i] + 16'h000A);
    // software saved its context, so a wake under a blocked status word is safe
    irq_block_bit <= 1'h1;
    foreach (modes[k]) begin
      apb(1'h1, A_C2, {24'h0, modes[k].c2});
      apb(1'h1, A_C1, {24'h0, modes[k].c1});
      enter_sleep(modes[k].pins, modes[k].run);
      apb(1'h0, A_ST, 32'h0);
      check(rd, modes[k].stat);
      wake(modes[k].src, 12'hA50 + 12'(k));
    end
    // in normal run a blocked request must not wake anything
    @(posedge clk);
    nmi_req <= 1'h1;
    @(posedge clk);
    nmi_req <= 1'h0;
    #1;
    check({wake_exc, irq_take, cpu_halt}, 3'h0);
    // with the block bit low a request in run is taken but wakes nothing
    irq_block_bit <= 1'h0;
    @(posedge clk);
    nmi_req <= 1'h1;
    @(posedge clk);
    nmi_req <= 1'h0;
    #1;
    check({wake_exc, irq_take, cpu_halt}, 3'h2);
    // manual reset ends sleep and clears only the stop register
    apb(1'h1, A_C1, 32'h0);
    apb(1'h1, A_C2, 32'h2);
    apb(1'h1, A_PS, 32'h5);
    enter_sleep(2'h2, 1'h1);
    @(posedge clk);
    manual_reset <= 1'h1;
    @(posedge clk);
    #1;
    check({cpu_halt, state_out_hi, state_out_lo}, 3'h7);
    @(posedge clk);
    manual_reset <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    check({cpu_halt, state_out_hi, state_out_lo}, 3'h0);
    apb(1'h0, A_PS, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, A_C2, 32'h0);
    check(rd, 32'h2);
    // hardware standby: pins driven low-high, or floated when the pin drive bit is clear
    apb(1'h1, A_C2, 32'h40);
    @(posedge clk);
    hw_standby <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    check({state_out_hi, state_out_lo, state_pin_oe}, 3'h3);
    apb(1'h0, A_ST, 32'h0);
    check(rd, 32'h18);
    apb(1'h1, A_C2, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    check(state_pin_oe, 1'h0);
    @(posedge clk);
    hw_standby <= 1'h0;
    // asynchronous reset in mid-run returns both registers to zero
    apb(1'h1, A_C2, 32'h83);
    apb(1'h1, A_PS, 32'h7);
    @(posedge clk);
    arst_n <= 1'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    apb(1'h0, A_C2, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, A_PS, 32'h0);
    check(rd, 32'h0);
    foreach (glitch[i]) check(glitch[i], 8'h00);
    conclude();
  end

  // the sequence needs well under a thousand cycles; this cuts a hang short
  initial begin
    #250000;
    error_cnt++;
    conclude();
  end
endmodule : slpcs_top_tb

`default_nettype wire
